// [hw/caw_axil.sv]
// axi4-lite slave front end: turns bus traffic into one-cycle register requests
// assumes one outstanding write and one outstanding read; read answer one cycle later
module caw_axil (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite
  input  wire logic [7:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [7:0]        s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // register side
  output caw_pkg::caw_req_s      req,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_ok,
  input  wire logic              wr_ok
);
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        do_wr, do_rd;

  assign s_awready = !aw_have_q && !bvalid_q;
  assign s_wready  = !w_have_q && !bvalid_q;
  // a read waits while a write is committing, since both share one request address
  assign s_arready = !rvalid_q && !(aw_have_q && w_have_q);
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;
  assign s_rvalid  = rvalid_q;
  assign s_rresp   = rresp_q;
  assign s_rdata   = rdata_q;

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_awvalid && s_awready) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_wdata;
      wstrb_d  = s_wstrb;
    end
    do_wr = aw_have_q && w_have_q;
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? 2'h0 : 2'h2;
    end
    if (bvalid_q && s_bready) begin
      bvalid_d = 1'b0;
    end
    do_rd = s_arvalid && s_arready;
    if (do_rd) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_data;
      rresp_d  = rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid_q && s_rready) begin
      rvalid_d = 1'b0;
    end
    req.wr    = do_wr;
    req.rd    = do_rd;
    req.addr  = do_rd ? s_araddr : awaddr_q;
    req.wdata = wdata_q;
    req.wstrb = wstrb_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end
endmodule : caw_axil

// [hw/caw_defines.svh]
// register offsets, field positions and reset values of the counter array watchdog
// assumes inclusion by bare name from the watchdog top and the bench
`ifndef CAW_DEFINES_SVH
`define CAW_DEFINES_SVH
`define CAW_OFF_ARRAY_MODE    8'h00
`define CAW_OFF_MOD4_MODE     8'h04
`define CAW_OFF_MOD4_CMP_LOW  8'h08
`define CAW_OFF_MOD4_CMP_HIGH 8'h0C
`define CAW_OFF_TIMER_LOW     8'h10
`define CAW_OFF_TIMER_HIGH    8'h14
`define CAW_OFF_IRQ_STATUS    8'h18
`define CAW_OFF_IRQ_MASK      8'h1C
`define CAW_BIT_WDT_EN        6
`define CAW_BIT_RUN           0
`define CAW_BIT_COMP_EN       6
`define CAW_BIT_MATCH_EN      3
`define CAW_BIT_TOGGLE        2
`define CAW_BIT_PWM           1
`define CAW_BIT_FLAG_IE       0
`define CAW_ARRAY_MODE_RST    8'h01
`define CAW_MOD4_MODE_RST     8'h00
`define CAW_CMP_RST           16'hFFFF
`define CAW_MOD4_MODE_MASK    8'h7F
`define CAW_ARRAY_MODE_MASK   8'h41
`define CAW_IRQ_MATCH         0
`define CAW_IRQ_WDT           1
`define CAW_IRQ_W             2
`endif

// [hw/caw_pkg.sv]
// types of the counter array watchdog
// assumes caw_defines.svh on the include path
package caw_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } caw_req_s;
  typedef enum logic [1:0] {CAW_IDLE, CAW_WRESP, CAW_RRESP} caw_bus_e;
endpackage : caw_pkg

// [hw/caw_timer.sv]
// shared 16-bit counter array time base, software writable per byte
// assumes write requests are one-cycle pulses from the register file
module caw_timer (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        run,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // time base
  output logic [15:0]      count
);
  logic [15:0] count_q, count_d;
  assign count = count_q;

  always_comb begin
    count_d = count_q;
    if (run) begin
      count_d = count_q + 16'h0001;
    end
    if (wr_low) begin
      count_d[7:0] = wdata;
    end
    if (wr_high) begin
      count_d[15:8] = wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : caw_timer

// [hw/caw_watchdog.sv]
// counter array watchdog top: module 4 compare, watchdog reset, registers over axi4-lite
// assumes the chip reset network takes wdt_reset_req as an internal-only source
`include "caw_defines.svh"

// Function
// - watchdog only on module 4; other compare modes stay usable otherwise
// - full 16-bit compare value checked against timer every cycle in compare mode, except between low and high byte writes
// - match with watchdog mode and reset enable raises internal reset
// - internal reset only; the external reset pin is never driven
// - clearing reset enable blocks the reset; setting again re-arms it
// - reset enable is bit 6 (mask 40H) of the array mode register
// - timer is software writable; avoid with other modules active
// - toggle bit 1 toggles the module output on match, 0 leaves it
// - one shared timer high/low pair is the single time base
module caw_watchdog (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // chip side
  output logic             wdt_reset_req,
  output logic             module_output_pin,
  output logic             irq
);
  caw_pkg::caw_req_s req;
  logic [31:0] rd_data;
  logic        rd_ok, wr_ok;
  logic [15:0] timer;
  logic        wr_tl, wr_th;

  logic [7:0]  array_mode_q, array_mode_d;
  logic [7:0]  mod4_mode_q, mod4_mode_d;
  logic [15:0] cmp_q, cmp_d;
  logic        cmp_hold_q, cmp_hold_d;
  logic        pin_q, pin_d;
  logic        rst_q, rst_d;
  logic [`CAW_IRQ_W-1:0] status_q, status_d;
  logic [`CAW_IRQ_W-1:0] mask_q, mask_d;
  logic        match_q, match_d;

  logic        wdt_en, compare_mode, match_now, match_rise;
  logic        lane0;
  logic [`CAW_IRQ_W-1:0] events;

  caw_axil u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .req       (req),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok),
    .wr_ok     (wr_ok)
  );

  // only one timer pair serves every consumer
  caw_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (array_mode_q[`CAW_BIT_RUN]),
    .wr_low  (wr_tl),
    .wr_high (wr_th),
    .wdata   (req.wdata[7:0]),
    .count   (timer)
  );

  assign lane0 = req.wr && req.wstrb[0];
  assign wr_tl = lane0 && (req.addr == `CAW_OFF_TIMER_LOW);
  assign wr_th = lane0 && (req.addr == `CAW_OFF_TIMER_HIGH);

  // compare mode: comparator and match enabled, pwm off
  assign compare_mode = mod4_mode_q[`CAW_BIT_COMP_EN] && mod4_mode_q[`CAW_BIT_MATCH_EN]
                        && !mod4_mode_q[`CAW_BIT_PWM];
  assign wdt_en    = array_mode_q[`CAW_BIT_WDT_EN];
  // comparator paused between low and high byte writes, as a partial value is meaningless
  assign match_now = compare_mode && !cmp_hold_q && (cmp_q == timer);
  assign match_rise = match_now && !match_q;

  assign events[`CAW_IRQ_MATCH] = match_rise;
  assign events[`CAW_IRQ_WDT]   = match_rise && wdt_en;

  always_comb begin
    array_mode_d = array_mode_q;
    mod4_mode_d  = mod4_mode_q;
    cmp_d        = cmp_q;
    cmp_hold_d   = cmp_hold_q;
    mask_d       = mask_q;
    status_d     = status_q;
    if (lane0) begin
      unique case (req.addr)
        `CAW_OFF_ARRAY_MODE:    array_mode_d = req.wdata[7:0] & `CAW_ARRAY_MODE_MASK;
        `CAW_OFF_MOD4_MODE:     mod4_mode_d  = req.wdata[7:0] & `CAW_MOD4_MODE_MASK;
        `CAW_OFF_MOD4_CMP_LOW: begin
          cmp_d[7:0] = req.wdata[7:0];
          cmp_hold_d = 1'b1;
        end
        `CAW_OFF_MOD4_CMP_HIGH: begin
          cmp_d[15:8] = req.wdata[7:0];
          cmp_hold_d  = 1'b0;
        end
        `CAW_OFF_IRQ_STATUS:    status_d = status_q & ~req.wdata[`CAW_IRQ_W-1:0];
        `CAW_OFF_IRQ_MASK:      mask_d   = req.wdata[`CAW_IRQ_W-1:0];
        default: ;
      endcase
    end
    // new events win over a simultaneous clear
    status_d = status_d | events;
    match_d  = match_now;
    pin_d    = pin_q ^ (match_rise && mod4_mode_q[`CAW_BIT_TOGGLE]);
    // internal reset level held while the match condition persists
    rst_d    = match_now && wdt_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      array_mode_q <= `CAW_ARRAY_MODE_RST;
      mod4_mode_q  <= `CAW_MOD4_MODE_RST;
      cmp_q        <= `CAW_CMP_RST;
      cmp_hold_q   <= 1'b0;
      mask_q       <= {`CAW_IRQ_W{1'b0}};
      status_q     <= {`CAW_IRQ_W{1'b0}};
      match_q      <= 1'b0;
      pin_q        <= 1'b0;
      rst_q        <= 1'b0;
    end else begin
      array_mode_q <= array_mode_d;
      mod4_mode_q  <= mod4_mode_d;
      cmp_q        <= cmp_d;
      cmp_hold_q   <= cmp_hold_d;
      mask_q       <= mask_d;
      status_q     <= status_d;
      match_q      <= match_d;
      pin_q        <= pin_d;
      rst_q        <= rst_d;
    end
  end

  // no external reset pin exists on this block: only the internal request
  assign wdt_reset_req     = rst_q;
  assign module_output_pin = pin_q;
  assign irq               = |(status_q & mask_q);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (req.addr)
      `CAW_OFF_ARRAY_MODE:    rd_data[7:0] = array_mode_q;
      `CAW_OFF_MOD4_MODE:     rd_data[7:0] = mod4_mode_q;
      `CAW_OFF_MOD4_CMP_LOW:  rd_data[7:0] = cmp_q[7:0];
      `CAW_OFF_MOD4_CMP_HIGH: rd_data[7:0] = cmp_q[15:8];
      `CAW_OFF_TIMER_LOW:     rd_data[7:0] = timer[7:0];
      `CAW_OFF_TIMER_HIGH:    rd_data[7:0] = timer[15:8];
      `CAW_OFF_IRQ_STATUS:    rd_data[`CAW_IRQ_W-1:0] = status_q;
      `CAW_OFF_IRQ_MASK:      rd_data[`CAW_IRQ_W-1:0] = mask_q;
      default:                rd_ok = 1'b0;
    endcase
    wr_ok = rd_ok;
  end

  a_reset_on_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (match_now && wdt_en) |=> wdt_reset_req) else $error("watchdog match without reset");
  a_reset_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    !wdt_en |=> !wdt_reset_req) else $error("reset while enable clear");
  a_reset_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wdt_reset_req) |-> $past(cmp_q) == $past(timer)) else $error("reset without match");
  a_enable_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    (lane0 && req.addr == `CAW_OFF_ARRAY_MODE) |=> wdt_en == $past(req.wdata[6]))
    else $error("reset enable not at bit 6");
  a_toggle_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (match_rise && mod4_mode_q[`CAW_BIT_TOGGLE]) |=> module_output_pin != $past(module_output_pin))
    else $error("pin did not toggle");
  a_pin_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !mod4_mode_q[`CAW_BIT_TOGGLE] |=> $stable(module_output_pin)) else $error("pin changed");
  a_timer_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (timer == 16'hFFFF && array_mode_q[0] && !wr_tl && !wr_th) |=> timer == 16'h0000)
    else $error("timer did not wrap");
  a_timer_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_th |=> timer[15:8] == $past(req.wdata[7:0])) else $error("timer write lost");
  a_other_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    !compare_mode |=> !wdt_reset_req) else $error("reset outside compare mode");
  a_hold_no_match: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_hold_q |-> !match_now) else $error("match on half-written compare value");
  a_high_releases: assert property (@(posedge aclk) disable iff (!aresetn)
    (lane0 && req.addr == `CAW_OFF_MOD4_CMP_HIGH) |=> !cmp_hold_q) else $error("compare pause stuck");
  a_reset_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
    wdt_reset_req |-> $past(wdt_en)) else $error("reset without enable");
  a_status_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    events[`CAW_IRQ_WDT] |=> status_q[`CAW_IRQ_WDT]) else $error("watchdog event lost");
  a_req_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
    !(req.wr && req.rd)) else $error("read and write share one request");
endmodule : caw_watchdog

// [verification/caw_watchdog_bench.sv]
// self-checking bench of the counter array watchdog: axi4-lite tasks and scripted checks
// assumes caw_defines.svh on the include path and a 25 MHz single clock domain
`include "caw_defines.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module caw_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_awaddr;
  logic        s_awvalid;
  logic        s_awready;
  logic [31:0] s_wdata;
  logic [3:0]  s_wstrb;
  logic        s_wvalid;
  logic        s_wready;
  logic [1:0]  s_bresp;
  logic        s_bvalid;
  logic        s_bready;
  logic [7:0]  s_araddr;
  logic        s_arvalid;
  logic        s_arready;
  logic [31:0] s_rdata;
  logic [1:0]  s_rresp;
  logic        s_rvalid;
  logic        s_rready;
  logic        wdt_reset_req;
  logic        module_output_pin;
  logic        irq;
  int          failures;
  int          compares;
  int          rst_cnt;

  caw_watchdog dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .wdt_reset_req(wdt_reset_req), .module_output_pin(module_output_pin), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // counted on the falling edge so it never races the bench's own edge sampling
  always @(negedge aclk) begin
    if (wdt_reset_req === 1'b1) rst_cnt++;
  end

  task automatic conclude;
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr  <= a;
    s_awvalid <= 1'b1;
    s_wdata   <= d;
    s_wstrb   <= 4'hF;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1) break;
      if (n > 100) begin
        failures++;
        conclude();
      end
    end
    s_bready <= 1'b0;
    `CHK(s_bresp, er)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) break;
      if (n > 100) begin
        failures++;
        conclude();
      end
    end
    s_rready <= 1'b0;
    `CHK(s_rdata, exp)
    `CHK(s_rresp, er)
  endtask : rd

  // stop the time base, load it and the compare value, then start with the chosen mode
  task automatic arm(input logic [7:0] m, input logic e, input logic [15:0] c);
    wr(`CAW_OFF_ARRAY_MODE, 32'h0);
    wr(`CAW_OFF_TIMER_LOW, 32'h0);
    wr(`CAW_OFF_TIMER_HIGH, 32'h0);
    wr(`CAW_OFF_MOD4_CMP_LOW, {24'h0, c[7:0]});
    wr(`CAW_OFF_MOD4_CMP_HIGH, {24'h0, c[15:8]});
    wr(`CAW_OFF_MOD4_MODE, {24'h0, m});
    wr(`CAW_OFF_ARRAY_MODE, {25'h0, e, 6'h01});
  endtask : arm

  logic [7:0] modes [5] = '{8'h4C, 8'h48, 8'h4C, 8'h42, 8'h00};
  logic       ens   [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

  initial begin
    int   base;
    int   exp_rst;
    logic pin0;
    logic cmp_mode;
    failures  = 0;
    compares  = 0;
    rst_cnt   = 0;
    aresetn   = 1'b0;
    s_awaddr  = 8'h00;
    s_awvalid = 1'b0;
    s_wdata   = 32'h0;
    s_wstrb   = 4'h0;
    s_wvalid  = 1'b0;
    s_bready  = 1'b0;
    s_araddr  = 8'h00;
    s_arvalid = 1'b0;
    s_rready  = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CAW_OFF_ARRAY_MODE, 32'h01);
    rd(`CAW_OFF_MOD4_MODE, 32'h00);
    rd(`CAW_OFF_MOD4_CMP_LOW, 32'hFF);
    rd(`CAW_OFF_MOD4_CMP_HIGH, 32'hFF);
    rd(`CAW_OFF_IRQ_MASK, 32'h00);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'hFF, 2'h2);
    // write and read back of the enable; unused bits must read back zero
    wr(`CAW_OFF_ARRAY_MODE, 32'h41);
    rd(`CAW_OFF_ARRAY_MODE, 32'h41);
    wr(`CAW_OFF_ARRAY_MODE, 32'hFF);
    rd(`CAW_OFF_ARRAY_MODE, 32'h41);
    wr(`CAW_OFF_ARRAY_MODE, 32'h00);
    wr(`CAW_OFF_TIMER_LOW, 32'h34);
    wr(`CAW_OFF_TIMER_HIGH, 32'h12);
    rd(`CAW_OFF_TIMER_LOW, 32'h34);
    rd(`CAW_OFF_TIMER_HIGH, 32'h12);
    // compare 0x0120 also passes 0x0020, so a low-byte-only compare fires twice
    for (int i = 0; i < 5; i++) begin
      pin0 = module_output_pin;
      base = rst_cnt;
      cmp_mode = modes[i][6] & modes[i][3] & ~modes[i][1];
      exp_rst = (cmp_mode && ens[i]) ? 1 : 0;
      arm(modes[i], ens[i], 16'h0120);
      repeat (400) @(posedge aclk);
      `CHK(rst_cnt - base, exp_rst)
      if (cmp_mode) `CHK(module_output_pin, pin0 ^ modes[i][2])
    end
    rd(`CAW_OFF_IRQ_STATUS, 32'h03);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    wr(`CAW_OFF_IRQ_MASK, 32'h02);
    @(negedge aclk);
    `CHK(irq, 1'b1)
    wr(`CAW_OFF_IRQ_STATUS, 32'h03);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    rd(`CAW_OFF_IRQ_STATUS, 32'h00);
    // refresh: low byte 00 then current high byte puts the match a wrap away
    base = rst_cnt;
    arm(8'h4C, 1'b1, 16'h0120);
    wr(`CAW_OFF_MOD4_CMP_LOW, 32'h00);
    wr(`CAW_OFF_MOD4_CMP_HIGH, 32'h00);
    repeat (400) @(posedge aclk);
    `CHK(rst_cnt - base, 0)
    conclude();
  end
endmodule : caw_watchdog_bench
